/* File: rmp_regs.sv */
// Purpose: register slice for invalidation event address and remap table
// Assumes: capability inputs and event strobe come from logic on pclk
// Notes:   zero wait state apb slave, answer latched in the setup cycle
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module rmp_regs
(
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [rmp_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // capability reports
   input  wire logic                          queued_invalidation_support,
   input  wire logic                          wide_destination_support,
   input  wire logic                          interrupt_remap_support,
   // invalidation event and outgoing message
   input  wire logic                          inv_event,
   output logic                               msg_valid,
   output logic      [63:0]                   msg_addr,
   output logic      [rmp_pkg::DATA_W-1:0]    msg_data,
   // remap table view
   input  wire logic [31:0]                   entry_dest_id,
   output logic      [31:0]                   dest_id,
   output logic      [rmp_pkg::TBL_BASE_W-1:0] table_base_field,
   output logic      [rmp_pkg::SIZE_W-1:0]    table_size,
   output logic      [rmp_pkg::ENTRIES_W-1:0] remap_table_entries,
   output logic                               wide_destination_enable,
   // interrupt
   output logic                               irq
);
   import rmp_pkg::*;

   // checks below all sample on pclk and sleep in reset
   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // decode: is this byte offset a mapped register
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == OFF_EV_CTRL) || (a == OFF_EV_DATA) ||
                  (a == OFF_EV_ADDR) || (a == OFF_EV_UADDR) ||
                  (a == OFF_TBL_LO) || (a == OFF_TBL_HI) ||
                  (a == OFF_INT_STAT) || (a == OFF_INT_MASK);
   endfunction

   // destination id seen by the walker for a given mode
   function automatic logic [31:0] dest_view(input logic wide,
                                             input logic [31:0] id);
      dest_view = wide ? id : 32'(id[NARROW_DEST_W-1:0]);
   endfunction

   // state
   logic [31:ADDR_FIELD_LSB] msg_addr_field_r, msg_addr_field_nxt;
   logic [31:0]              msg_upper_addr_field_r, msg_upper_addr_field_nxt;
   logic [TBL_BASE_W-1:0]    table_base_r, table_base_nxt;
   logic [SIZE_W-1:0]        size_r, size_nxt;
   logic                     wide_r, wide_nxt;
   logic [ENTRIES_W-1:0]     entries_r, entries_nxt;
   logic                     event_mask_bit_r, event_mask_bit_nxt;
   logic                     pend_r, pend_nxt;
   logic [DATA_W-1:0]        event_data_value_r, event_data_value_nxt;
   logic [NUM_IRQ-1:0]       ist_r, ist_nxt;
   logic [NUM_IRQ-1:0]       imask_r, imask_nxt;
   logic                     irq_r, irq_nxt;
   logic                     mv_r, mv_nxt;
   logic [63:0]              maddr_r, maddr_nxt;
   logic [DATA_W-1:0]        md_r, md_nxt;
   logic [31:0]              dest_r, dest_nxt;
   logic [31:0]              prdata_r, prdata_nxt;
   logic                     pready_r, pready_nxt;
   logic                     pslverr_r, pslverr_nxt;

   // helper terms
   logic                     setup, wr_take, queue_ok, upper_ok, send;
   logic [NUM_IRQ-1:0]       ev_set;
   logic [31:0]              rd_word;

   assign setup   = psel && !penable;
   assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
   assign queue_ok = queued_invalidation_support;
   assign upper_ok = queued_invalidation_support && wide_destination_support;
   assign send    = pend_r && !event_mask_bit_r;

   // read mux over stored state, unmapped words read zero
   always_comb
   begin
      rd_word = WORD_ZERO;
      unique case (paddr)
         OFF_EV_CTRL:  rd_word = (WORD_ZERO | {event_mask_bit_r, pend_r})
                                 << EV_PEND_BIT;
         OFF_EV_DATA:  rd_word = {16'h0000, event_data_value_r};
         OFF_EV_ADDR:  rd_word = {msg_addr_field_r, 2'b00};
         OFF_EV_UADDR: rd_word = msg_upper_addr_field_r;
         OFF_TBL_LO:   rd_word = {table_base_r[LO_BASE_W-1:0], wide_r, 7'h00,
                                  size_r};
         OFF_TBL_HI:   rd_word = 32'(table_base_r[TBL_BASE_W-1:LO_BASE_W]);
         OFF_INT_STAT: rd_word = 32'(ist_r);
         OFF_INT_MASK: rd_word = 32'(imask_r);
         default:      rd_word = WORD_ZERO;
      endcase
   end

   // next state for apb answer, registers, event path and outputs
   always_comb
   begin
      msg_addr_field_nxt       = msg_addr_field_r;
      msg_upper_addr_field_nxt = msg_upper_addr_field_r;
      table_base_nxt           = table_base_r;
      size_nxt                 = size_r;
      wide_nxt                 = wide_r;
      event_mask_bit_nxt       = event_mask_bit_r;
      event_data_value_nxt     = event_data_value_r;
      imask_nxt                = imask_r;
      // apb: answer prepared in setup, released after access
      pready_nxt  = setup;
      pslverr_nxt = setup && !is_mapped(paddr);
      prdata_nxt  = setup ? rd_word : prdata_r;
      if (wr_take)
      begin
         unique case (paddr)
            OFF_EV_CTRL:  event_mask_bit_nxt = pwdata[EV_MASK_BIT];
            OFF_EV_DATA:  event_data_value_nxt = pwdata[DATA_W-1:0];
            OFF_EV_ADDR:  msg_addr_field_nxt =
                             pwdata[31:ADDR_FIELD_LSB];
            OFF_EV_UADDR: msg_upper_addr_field_nxt = pwdata;
            OFF_TBL_LO:
            begin
               table_base_nxt[LO_BASE_W-1:0] = pwdata[31:TBL_BASE_LSB];
               wide_nxt = pwdata[WIDE_BIT];
               size_nxt = pwdata[SIZE_W-1:0];
            end
            OFF_TBL_HI:   table_base_nxt[TBL_BASE_W-1:LO_BASE_W] =
                             pwdata[TBL_BASE_W-LO_BASE_W-1:0];
            OFF_INT_MASK: imask_nxt = pwdata[NUM_IRQ-1:0];
            default:      imask_nxt = imask_r;
         endcase
      end
      // capability gating keeps unsupported space at zero
      if (!queue_ok)
      begin
         msg_addr_field_nxt   = '0;
         event_data_value_nxt = '0;
      end
      if (!upper_ok)
         msg_upper_addr_field_nxt = '0;
      if (!wide_destination_support)
         wide_nxt = 1'b0;
      if (!interrupt_remap_support)
      begin
         table_base_nxt = '0;
         wide_nxt       = 1'b0;
         size_nxt       = '0;
      end
      entries_nxt = ENTRIES_W'(1) << (size_nxt + 5'd1);
      dest_nxt    = dest_view(wide_r, entry_dest_id);
      // event pending until message goes out
      pend_nxt = queue_ok && ((pend_r && !send) || inv_event);
      mv_nxt   = send;
      maddr_nxt = send ? {msg_upper_addr_field_r, msg_addr_field_r, 2'b00}
                       : maddr_r;
      md_nxt   = send ? event_data_value_r : md_r;
      // sticky status, set wins over write-one clear
      ev_set  = {send, queue_ok && inv_event};
      ist_nxt = ist_r;
      if (wr_take && paddr == OFF_INT_STAT)
         ist_nxt = ist_r & ~pwdata[NUM_IRQ-1:0];
      ist_nxt = ist_nxt | ev_set;
      irq_nxt = |(ist_r & imask_r);
   end

   // register stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         msg_addr_field_r       <= '0;
         msg_upper_addr_field_r <= '0;
         table_base_r           <= '0;
         size_r                 <= '0;
         wide_r                 <= 1'b0;
         entries_r              <= ENTRIES_W'(2);
         event_mask_bit_r       <= EV_MASK_RST;
         pend_r                 <= 1'b0;
         event_data_value_r     <= '0;
         ist_r                  <= '0;
         imask_r                <= '0;
         irq_r                  <= 1'b0;
         mv_r                   <= 1'b0;
         maddr_r                <= '0;
         md_r                   <= '0;
         dest_r                 <= '0;
         prdata_r               <= '0;
         pready_r               <= 1'b0;
         pslverr_r              <= 1'b0;
      end
      else
      begin
         msg_addr_field_r       <= msg_addr_field_nxt;
         msg_upper_addr_field_r <= msg_upper_addr_field_nxt;
         table_base_r           <= table_base_nxt;
         size_r                 <= size_nxt;
         wide_r                 <= wide_nxt;
         entries_r              <= entries_nxt;
         event_mask_bit_r       <= event_mask_bit_nxt;
         pend_r                 <= pend_nxt;
         event_data_value_r     <= event_data_value_nxt;
         ist_r                  <= ist_nxt;
         imask_r                <= imask_nxt;
         irq_r                  <= irq_nxt;
         mv_r                   <= mv_nxt;
         maddr_r                <= maddr_nxt;
         md_r                   <= md_nxt;
         dest_r                 <= dest_nxt;
         prdata_r               <= prdata_nxt;
         pready_r               <= pready_nxt;
         pslverr_r              <= pslverr_nxt;
      end
   end

   // outputs straight from flops
   assign prdata                  = prdata_r;
   assign pready                  = pready_r;
   assign pslverr                 = pslverr_r;
   assign msg_valid               = mv_r;
   assign msg_addr                = maddr_r;
   assign msg_data                = md_r;
   assign dest_id                 = dest_r;
   assign table_base_field        = table_base_r;
   assign table_size              = size_r;
   assign remap_table_entries     = entries_r;
   assign wide_destination_enable = wide_r;
   assign irq                     = irq_r;

   // checks, clock and reset taken from the defaults at the top
   a_addr_low_zero: assert property (
      pready && psel && !pwrite && $past(paddr) == OFF_EV_ADDR
      |-> prdata[1:0] == 2'b00)
      else $error("event address low bits not zero");
   a_addr_no_queue: assert property (
      !$past(queued_invalidation_support) |-> msg_addr_field_r == '0)
      else $error("event address kept without queued invalidation");
   a_upper_write: assert property (
      wr_take && paddr == OFF_EV_UADDR && upper_ok
      |=> msg_upper_addr_field_r == $past(pwdata))
      else $error("upper address write lost");
   a_upper_zero: assert property (
      !$past(upper_ok) |-> msg_upper_addr_field_r == '0)
      else $error("upper address kept without support");
   a_base_write: assert property (
      wr_take && paddr == OFF_TBL_LO && interrupt_remap_support
      |=> table_base_r[LO_BASE_W-1:0] == $past(pwdata[31:TBL_BASE_LSB]))
      else $error("table base low write lost");
   a_base_hold: assert property (
      !wr_take && interrupt_remap_support |=> $stable(table_base_r))
      else $error("table base changed without write");
   a_narrow_dest: assert property (
      !wide_r |=> dest_id[31:NARROW_DEST_W] == '0
                  && dest_id[NARROW_DEST_W-1:0]
                     == $past(entry_dest_id[NARROW_DEST_W-1:0]))
      else $error("narrow destination not trimmed");
   a_wide_dest: assert property (
      wide_r |=> dest_id == $past(entry_dest_id))
      else $error("wide destination altered");
   a_wide_nosup: assert property (
      !$past(wide_destination_support) |-> !wide_destination_enable)
      else $error("wide enable set without support");
   a_entries: assert property (
      remap_table_entries == (ENTRIES_W'(1) << (size_r + 1)))
      else $error("entry count wrong");
   a_tbl_no_remap: assert property (
      !$past(interrupt_remap_support) |-> table_base_r == '0 && size_r == '0)
      else $error("table register kept without remap support");
   a_msg_send: assert property (
      send && !inv_event |=> msg_valid ##1 !msg_valid)
      else $error("message not sent for unmasked event");
   a_msg_payload: assert property (
      msg_valid |-> msg_data == $past(event_data_value_r))
      else $error("message payload differs from event data");
   a_masked_quiet: assert property (
      event_mask_bit_r |=> !msg_valid)
      else $error("message sent while masked");
endmodule // rmp_regs

`default_nettype wire

/* File: rmp_pkg.sv */
// Purpose: constants for the remap event and table register slice
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes:   host address width is fixed here for this build
package rmp_pkg;
   // apb address width and register byte offsets
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFF_EV_CTRL     = 12'h0a0;
   localparam logic [11:0] OFF_EV_DATA     = 12'h0a4;
   localparam logic [11:0] OFF_EV_ADDR     = 12'h0a8;
   localparam logic [11:0] OFF_EV_UADDR    = 12'h0ac;
   localparam logic [11:0] OFF_TBL_LO      = 12'h0b8;
   localparam logic [11:0] OFF_TBL_HI      = 12'h0bc;
   localparam logic [11:0] OFF_INT_STAT    = 12'h0c0;
   localparam logic [11:0] OFF_INT_MASK    = 12'h0c4;
   // host address width and table base field bounds
   localparam int          HOST_ADDR_WIDTH = 48;
   localparam int          TBL_BASE_LSB    = 12;
   localparam int          TBL_BASE_W      = HOST_ADDR_WIDTH - TBL_BASE_LSB;
   localparam int          LO_BASE_W       = 32 - TBL_BASE_LSB;
   // field positions
   localparam int          ADDR_FIELD_LSB  = 2;
   localparam int          WIDE_BIT        = 11;
   localparam int          SIZE_W          = 4;
   localparam int          EV_MASK_BIT     = 31;
   localparam int          EV_PEND_BIT     = 30;
   localparam int          DATA_W          = 16;
   localparam int          NARROW_DEST_W   = 8;
   localparam int          ENTRIES_W       = 17;
   // interrupt status bits: event seen, message sent
   localparam int          NUM_IRQ         = 2;
   localparam int          IRQ_EVENT       = 0;
   localparam int          IRQ_SENT        = 1;
   // reset values
   localparam logic        EV_MASK_RST     = 1'b1;
   localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
endpackage

/* File: rmp_tb.sv */
// Purpose: self-checking bench for the remap event and table register slice
// Assumes: zero wait state apb slave, capability levels driven by the bench
// Notes:   one task per scenario, each judges what it sees before returning
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rmp_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, entry_dest_id, dest_id, rd;
   logic        queue_sup, wide_sup, remap_sup, inv_event, msg_valid, wide_en;
   logic        irq, err;
   logic [63:0] msg_addr;
   logic [15:0] msg_data;
   logic [35:0] tbl_base;
   logic [3:0]  tbl_size;
   logic [16:0] n_entries;
   int          n_errors, total_checks;

   // device under test, every port reached by the bench
   rmp_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .queued_invalidation_support(queue_sup),
      .wide_destination_support(wide_sup),
      .interrupt_remap_support(remap_sup), .inv_event(inv_event),
      .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
      .entry_dest_id(entry_dest_id), .dest_id(dest_id),
      .table_base_field(tbl_base), .table_size(tbl_size),
      .remap_table_entries(n_entries),
      .wide_destination_enable(wide_en), .irq(irq));

   // 25 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // closing report, the only place the run ends
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // a bound ran out: count it and close
   task automatic hang();
      n_errors++;
      print_verdict();
   endtask

   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 8);
      if (pready !== 1'b1)
         hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read a register and compare its word
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk(err, 1'b0);
   endtask

   // one-cycle invalidation event
   task automatic pulse();
      @(posedge pclk);
      inv_event <= 1'b1;
      @(posedge pclk);
      inv_event <= 1'b0;
   endtask

   // bounded wait for an outgoing message
   task automatic wait_msg();
      int k;
      for (k = 0; k < 20 && msg_valid !== 1'b1; k++)
         @(posedge pclk);
      if (msg_valid !== 1'b1)
         hang();
   endtask

   // bounded wait for the interrupt line to reach a level
   task automatic wait_irq(input logic lvl);
      int k;
      for (k = 0; k < 10 && irq !== lvl; k++)
         @(posedge pclk);
      chk(irq, lvl);
   endtask

   // values straight after reset
   task automatic t_reset();
      rchk(OFF_EV_ADDR, WORD_ZERO);
      rchk(OFF_EV_UADDR, WORD_ZERO);
      rchk(OFF_TBL_LO, WORD_ZERO);
      rchk(OFF_TBL_HI, WORD_ZERO);
      rchk(OFF_EV_CTRL, 32'h8000_0000);
      chk(n_entries, 17'h00002);
      chk(irq, 1'b0);
   endtask

   // field storage, reserved bits and derived table outputs
   task automatic t_fields();
      apb(1'b1, OFF_EV_ADDR, 32'hffff_ffff);
      rchk(OFF_EV_ADDR, 32'hffff_fffc);
      apb(1'b1, OFF_EV_UADDR, 32'ha5a5_5a5a);
      rchk(OFF_EV_UADDR, 32'ha5a5_5a5a);
      apb(1'b1, OFF_TBL_LO, 32'hffff_ffff);
      rchk(OFF_TBL_LO, 32'hffff_f80f);
      apb(1'b1, OFF_TBL_HI, 32'hffff_ffff);
      rchk(OFF_TBL_HI, 32'h0000_ffff);
      chk(tbl_base, 36'hf_ffff_ffff);
      chk(tbl_size, 4'hf);
      chk(n_entries, 17'h10000);
      chk(wide_en, 1'b1);
      entry_dest_id <= 32'h1234_5678;
      repeat (2) @(posedge pclk);
      chk(dest_id, 32'h1234_5678);
      apb(1'b1, OFF_TBL_LO, 32'h1234_5003);
      rchk(OFF_TBL_LO, 32'h1234_5003);
      chk(tbl_base, 36'hf_fff1_2345);
      chk(n_entries, 17'h00010);
      chk(dest_id, 32'h0000_0078);
   endtask

   // message build, interrupt status, mask and held-back message
   task automatic t_event();
      apb(1'b1, OFF_EV_DATA, 32'hdead_abcd);
      rchk(OFF_EV_DATA, 32'h0000_abcd);
      apb(1'b1, OFF_EV_ADDR, 32'h1234_5678);
      apb(1'b1, OFF_EV_UADDR, 32'h0bad_cafe);
      apb(1'b1, OFF_INT_MASK, 32'h0000_0003);
      apb(1'b1, OFF_EV_CTRL, WORD_ZERO);
      pulse();
      wait_msg();
      chk(msg_addr, 64'h0bad_cafe_1234_5678);
      chk(msg_data, 16'habcd);
      wait_irq(1'b1);
      rchk(OFF_INT_STAT, 32'h0000_0003);
      apb(1'b1, OFF_INT_STAT, 32'h0000_0003);
      wait_irq(1'b0);
      rchk(OFF_INT_STAT, WORD_ZERO);
      // masked event with interrupt mask off: held, irq stays low
      apb(1'b1, OFF_INT_MASK, WORD_ZERO);
      apb(1'b1, OFF_EV_CTRL, 32'h8000_0000);
      pulse();
      repeat (6)
      begin
         @(posedge pclk);
         chk(msg_valid, 1'b0);
      end
      rchk(OFF_EV_CTRL, 32'hc000_0000);
      apb(1'b1, OFF_EV_CTRL, WORD_ZERO);
      wait_msg();
      chk(msg_data, 16'habcd);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
      rchk(OFF_INT_STAT, 32'h0000_0003);
      apb(1'b1, OFF_INT_STAT, 32'h0000_0003);
   endtask

   // unmapped address answers with an error and zero data
   task automatic t_unmapped();
      apb(1'b1, 12'h010, 32'hffff_ffff);
      chk(err, 1'b1);
      apb(1'b0, 12'h010, WORD_ZERO);
      chk(err, 1'b1);
      chk(rd, WORD_ZERO);
   endtask

   // capability reports turn registers into reserved-zero space
   task automatic t_caps();
      @(posedge pclk);
      queue_sup <= 1'b0;
      apb(1'b1, OFF_EV_ADDR, 32'hffff_ffff);
      rchk(OFF_EV_ADDR, WORD_ZERO);
      rchk(OFF_EV_UADDR, WORD_ZERO);
      queue_sup <= 1'b1;
      wide_sup <= 1'b0;
      apb(1'b1, OFF_EV_UADDR, 32'hffff_ffff);
      rchk(OFF_EV_UADDR, WORD_ZERO);
      apb(1'b1, OFF_TBL_LO, 32'h0000_0801);
      rchk(OFF_TBL_LO, 32'h0000_0001);
      chk(wide_en, 1'b0);
      wide_sup <= 1'b1;
      remap_sup <= 1'b0;
      apb(1'b1, OFF_TBL_LO, 32'hffff_ffff);
      rchk(OFF_TBL_LO, WORD_ZERO);
      rchk(OFF_TBL_HI, WORD_ZERO);
      remap_sup <= 1'b1;
   endtask

   // main sequence: drive everything at time zero, reset, scenarios
   initial
   begin
      n_errors = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      queue_sup = 1'b1;
      wide_sup = 1'b1;
      remap_sup = 1'b1;
      inv_event = 1'b0;
      entry_dest_id = 32'h0000_0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_event();
      t_unmapped();
      t_caps();
      print_verdict();
   end
endmodule // tb
`default_nettype wire
